// >>> rtl/rprs_cfg_if.sv
// rprs_cfg_if: settings from the register file to the sequencer core
// and status back; both ends on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface rprs_cfg_if;
  import rprs_pkg::*;
  logic hs_sel;
  logic abs_est;
  rprs_axes_t final_minus;
  rprs_speed_t home_feed;
  rprs_speed_t app_feed;
  rprs_speed_t rapid_feed;
  rprs_axes_t reached;
  rprs_axes_t established;
  logic mode_active;
  logic alm_mode;
  logic alm_dir;
  modport regs (output hs_sel, abs_est, final_minus, home_feed, app_feed,
    rapid_feed, input reached, established, mode_active, alm_mode, alm_dir);
  modport core (input hs_sel, abs_est, final_minus, home_feed, app_feed,
    rapid_feed, output reached, established, mode_active, alm_mode, alm_dir);
endinterface
`default_nettype wire

// >>> rtl/rprs_mode_chk.sv
// rprs_mode_chk: homing mode entry and mode conflict detection
// assumes mode selects are synchronous levels from the ladder logic
`timescale 1ns/1ps
`default_nettype none
module rprs_mode_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic homing_mode_select,
  input wire logic [7:0] other_mode_select,
  input wire logic any_busy,
  output logic mode_active,
  output logic alm_mode
);
  import rprs_pkg::*;
  typedef struct packed {
    logic prev_sel;
    logic active;
    logic alm;
  } rprs_mode_s;
  rprs_mode_s r_reg, r_next;

  always_comb begin
    r_next.prev_sel = homing_mode_select;
    r_next.active = homing_mode_select && !(|other_mode_select); // [RULE1]
    // duplicate mode, or mode dropped while an axis still moves
    r_next.alm = (homing_mode_select && |other_mode_select) ||
      (r_reg.prev_sel && !homing_mode_select && any_busy); // [RULE3]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign mode_active = r_reg.active;
  assign alm_mode = r_reg.alm;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_mode_entry: assert property (homing_mode_select && // [RULE1]
    other_mode_select == 8'h00 |=> mode_active)
    else $error("homing mode not entered");
endmodule
`default_nettype wire

// >>> rtl/rprs_pkg.sv
// rprs_pkg: constants and types of the reference point return sequencer
// assumes one 40 MHz clock and a plain one-cycle register port
package rprs_pkg;
  localparam int NUM_AXES = 3;
  localparam int SPD_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MODE_W = 8;
  localparam int CODE_W = 5;
  typedef logic [SPD_W-1:0] rprs_speed_t;
  typedef logic [ADDR_W-1:0] rprs_addr_t;
  typedef logic [DATA_W-1:0] rprs_data_t;
  typedef logic [NUM_AXES-1:0] rprs_axes_t;
  typedef logic [15:0] rprs_alm_t;
  // byte addresses of the register words
  localparam rprs_addr_t OFS_CTRL = 8'h00;
  localparam rprs_addr_t OFS_HOME_FEED = 8'h04;
  localparam rprs_addr_t OFS_APPR_FEED = 8'h08;
  localparam rprs_addr_t OFS_RAPID_FEED = 8'h0c;
  localparam rprs_addr_t OFS_STATUS = 8'h10;
  localparam rprs_addr_t OFS_ALARM = 8'h14;
  // field positions
  localparam int CTRL_HS_SEL = 0;
  localparam int CTRL_ABS_EST = 1;
  localparam int CTRL_FINAL_LSB = 2;
  localparam int STAT_REACHED_LSB = 0;
  localparam int STAT_EST_LSB = 3;
  localparam int STAT_MODE = 6;
  localparam int STAT_ALARM = 7;
  // reset values, manual feed step and alarm codes
  localparam rprs_speed_t HOME_FEED_RST = 16'h1000;
  localparam rprs_speed_t APPR_FEED_RST = 16'h0100;
  localparam rprs_speed_t RAPID_FEED_RST = 16'h4000;
  localparam rprs_axes_t FINAL_MINUS_RST = 3'h0;
  localparam rprs_speed_t MAN_STEP = 16'h0040;
  localparam rprs_alm_t ALM_NONE = 16'h0000;
  localparam rprs_alm_t ALM_MODE = 16'h0101;
  localparam rprs_alm_t ALM_DIR = 16'h0003;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FEED = 3'b001,
    ST_PASS = 3'b010,
    ST_APPR = 3'b011,
    ST_DONE = 3'b100
  } rprs_st_e;
endpackage

// >>> rtl/rprs_regs.sv
// rprs_regs: register slave and sticky operation alarm
// assumes one-cycle strobes, read data valid only the cycle after rd
`timescale 1ns/1ps
`default_nettype none
module rprs_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rprs_pkg::rprs_addr_t reg_addr,
  input wire rprs_pkg::rprs_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic op_alarm,
  output logic [15:0] op_alarm_code,
  rprs_cfg_if.regs c
);
  import rprs_pkg::*;
  typedef struct packed {
    logic hs_sel;
    logic abs_est;
    rprs_axes_t final_minus;
    rprs_speed_t home_feed;
    rprs_speed_t app_feed;
    rprs_speed_t rapid_feed;
    rprs_alm_t code;
    logic alarm;
    rprs_data_t rdata;
  } rprs_regs_s;
  rprs_regs_s r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          r_next.hs_sel = reg_wdata[CTRL_HS_SEL];
          r_next.abs_est = reg_wdata[CTRL_ABS_EST];
          r_next.final_minus = reg_wdata[CTRL_FINAL_LSB +: NUM_AXES];
        end
        OFS_HOME_FEED: r_next.home_feed = reg_wdata[SPD_W-1:0];
        OFS_APPR_FEED: r_next.app_feed = reg_wdata[SPD_W-1:0];
        OFS_RAPID_FEED: r_next.rapid_feed = reg_wdata[SPD_W-1:0];
        OFS_ALARM: begin
          r_next.code = ALM_NONE;
          r_next.alarm = 1'b0;
        end
        default: r_next.rdata = '0;
      endcase
    end
    // new alarms land after the clear so that a clear never loses an event; 0101 overwrites 0003 in the same cycle
    if (c.alm_dir) begin
      r_next.code = ALM_DIR;
      r_next.alarm = 1'b1;
    end
    if (c.alm_mode) begin
      r_next.code = ALM_MODE;
      r_next.alarm = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: r_next.rdata = {27'h0, r_reg.final_minus, r_reg.abs_est,
          r_reg.hs_sel};
        OFS_HOME_FEED: r_next.rdata = {16'h0, r_reg.home_feed};
        OFS_APPR_FEED: r_next.rdata = {16'h0, r_reg.app_feed};
        OFS_RAPID_FEED: r_next.rdata = {16'h0, r_reg.rapid_feed};
        OFS_STATUS: r_next.rdata = {24'h0, r_reg.alarm, c.mode_active,
          c.established, c.reached};
        OFS_ALARM: r_next.rdata = {16'h0, r_reg.code};
        default: r_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg <= '{1'b0, 1'b0, FINAL_MINUS_RST, HOME_FEED_RST, APPR_FEED_RST,
        RAPID_FEED_RST, ALM_NONE, 1'b0, 32'h0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign op_alarm = r_reg.alarm;
  assign op_alarm_code = r_reg.code;
  assign c.hs_sel = r_reg.hs_sel;
  assign c.abs_est = r_reg.abs_est;
  assign c.final_minus = r_reg.final_minus;
  assign c.home_feed = r_reg.home_feed;
  assign c.app_feed = r_reg.app_feed;
  assign c.rapid_feed = r_reg.rapid_feed;
endmodule
`default_nettype wire

// >>> rtl/rprs_top.sv
// rprs_top: reference point return sequencer for three axes
// assumes ladder inputs, dog and reference point inputs are synchronous
// to ref_clk and that motion control follows move, direction and speed
//
// Notes on behaviour
// [RULE1] homing mode is active while its select is high and no other
// [RULE2] ladder raises plus or minus feed select of an axis to start it
// [RULE3] duplicate mode or mode dropped during motion raises alarm 0101
// [RULE4] first homing after reset is dog-type unless absolute est. set
// [RULE5] after establishment, pattern is chosen by the high-speed bit
// [RULE6] dog-type path depends on trip direction versus final direction
// [RULE7] once approach starts, axis completes even if select released
// [RULE8] another axis may start once no axis is before approach
// [RULE9] final entry direction after the dog comes from a setting
// [RULE10] dog-type pre-approach speed: homing feed if rapid, else manual
// [RULE11] approach speed comes from a setting
// [RULE12] at reference point the axis stops and its reached flag rises
// [RULE13] high-speed speed: rapid feed if rapid, else manual feed
// [RULE14] high-speed accepts only toward the point; else alarm 0003
// [RULE15] reached flag drops when axis leaves point or mode is left
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module rprs_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rprs_pkg::rprs_addr_t reg_addr,
  input wire rprs_pkg::rprs_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic homing_mode_select,
  input wire logic [7:0] other_mode_select,
  input wire rprs_pkg::rprs_axes_t feed_select_plus,
  input wire rprs_pkg::rprs_axes_t feed_select_minus,
  input wire logic rapid_traverse_select,
  input wire logic [4:0] manual_feedrate_code,
  input wire rprs_pkg::rprs_axes_t near_dog,
  input wire rprs_pkg::rprs_axes_t at_ref_point,
  output rprs_pkg::rprs_axes_t axis_move,
  output rprs_pkg::rprs_axes_t axis_dir_minus,
  output logic [47:0] axis_speed,
  output rprs_pkg::rprs_axes_t ref_point_reached_flag,
  output logic op_alarm,
  output logic [15:0] op_alarm_code
);
  import rprs_pkg::*;

  typedef struct packed {
    rprs_st_e [NUM_AXES-1:0] st;
    rprs_axes_t fast;
    rprs_axes_t dir_minus;
    rprs_axes_t reached;
    rprs_axes_t established;
    rprs_axes_t move;
    rprs_speed_t [NUM_AXES-1:0] speed;
    logic alm_dir;
  } rprs_top_s;

  rprs_top_s r, r_next;
  rprs_cfg_if cfg ();
  logic mode_active;
  logic alm_mode;
  rprs_axes_t pre_busy;
  rprs_speed_t man_spd;
  rprs_speed_t dog_spd;
  rprs_speed_t fast_spd;

  // manual feed code scaled to a speed word
  function automatic rprs_speed_t man_speed(input logic [4:0] code);
    man_speed = SPD_W'(code) * MAN_STEP;
  endfunction

  // true when an axis other than idx is still before its approach
  function automatic logic others_pre(input rprs_axes_t busy,
    input int idx);
    rprs_axes_t mask;
    mask = busy;
    mask[idx] = 1'b0;
    others_pre = |mask;
  endfunction

  function automatic rprs_speed_t phase_speed(input rprs_st_e st,
    input logic fast, input rprs_speed_t dog_s, input rprs_speed_t fast_s,
    input rprs_speed_t app_s);
    case (st)
      ST_FEED, ST_PASS: phase_speed = fast ? fast_s : dog_s;
      ST_APPR: phase_speed = app_s;
      default: phase_speed = '0;
    endcase
  endfunction

  rprs_regs u_regs (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .op_alarm(op_alarm),
    .op_alarm_code(op_alarm_code),
    .c(cfg.regs)
  );

  rprs_mode_chk u_mode (
    .ref_clk(ref_clk),
    .rst(rst),
    .homing_mode_select(homing_mode_select),
    .other_mode_select(other_mode_select),
    .any_busy(|r.move),
    .mode_active(mode_active),
    .alm_mode(alm_mode)
  );

  assign man_spd = man_speed(manual_feedrate_code);
  assign dog_spd = rapid_traverse_select ? cfg.home_feed : man_spd; // [RULE10]
  assign fast_spd = rapid_traverse_select ? cfg.rapid_feed : man_spd; // [RULE13]

  always_comb begin
    for (int i = 0; i < NUM_AXES; i++) begin
      pre_busy[i] = (r.st[i] == ST_FEED) || (r.st[i] == ST_PASS);
    end
  end

  always_comb begin
    logic claim;
    logic want_any;
    logic want_m;
    logic held;
    logic fast_ok;
    claim = 1'b0;
    want_any = 1'b0;
    want_m = 1'b0;
    held = 1'b0;
    fast_ok = 1'b0;
    r_next = r;
    r_next.alm_dir = 1'b0;
    for (int i = 0; i < NUM_AXES; i++) begin
      // pressing both directions counts as no request
      want_any = feed_select_plus[i] ^ feed_select_minus[i];
      want_m = feed_select_minus[i];
      held = r.dir_minus[i] ? feed_select_minus[i] : feed_select_plus[i];
      fast_ok = cfg.hs_sel && (cfg.abs_est || r.established[i]); // [RULE4] [RULE5]
      if (!at_ref_point[i]) begin
        r_next.reached[i] = 1'b0; // [RULE15]
      end
      if (!mode_active) begin
        // leaving the mode aborts motion at once
        r_next.st[i] = ST_IDLE;
        r_next.reached[i] = 1'b0; // [RULE15]
      end else begin
        case (r.st[i])
          ST_IDLE: begin
            // one start per cycle keeps at most one axis before approach
            if (want_any && !claim && !others_pre(pre_busy, i)) begin // [RULE8]
              if (fast_ok && want_m != cfg.final_minus[i]) begin
                r_next.alm_dir = 1'b1; // [RULE14]
              end else begin
                claim = 1'b1;
                r_next.st[i] = ST_FEED; // [RULE2]
                r_next.fast[i] = fast_ok;
                r_next.dir_minus[i] = want_m;
              end
            end
          end
          ST_FEED: begin
            if (!held) begin
              r_next.st[i] = ST_IDLE;
            end else if (r.fast[i]) begin
              if (at_ref_point[i]) begin
                r_next.st[i] = ST_DONE; // [RULE12]
                r_next.reached[i] = 1'b1;
                r_next.established[i] = 1'b1;
              end
            end else if (near_dog[i]) begin
              if (r.dir_minus[i] == cfg.final_minus[i]) begin
                r_next.st[i] = ST_APPR; // [RULE6]
                r_next.dir_minus[i] = cfg.final_minus[i]; // [RULE9]
              end else begin
                r_next.st[i] = ST_PASS; // [RULE6]
              end
            end
          end
          ST_PASS: begin
            // run through the dog, then turn round onto the final direction
            if (!held) begin
              r_next.st[i] = ST_IDLE;
            end else if (!near_dog[i]) begin
              r_next.st[i] = ST_APPR;
              r_next.dir_minus[i] = cfg.final_minus[i]; // [RULE9]
            end
          end
          ST_APPR: begin
            // feed select no longer matters here
            if (at_ref_point[i]) begin // [RULE7]
              r_next.st[i] = ST_DONE; // [RULE12]
              r_next.reached[i] = 1'b1;
              r_next.established[i] = 1'b1;
            end
          end
          ST_DONE: begin
            // stays stopped until the selects are released
            if (!feed_select_plus[i] && !feed_select_minus[i]) begin
              r_next.st[i] = ST_IDLE;
            end
          end
          default: r_next.st[i] = ST_IDLE;
        endcase
      end
      r_next.move[i] = (r_next.st[i] == ST_FEED) ||
        (r_next.st[i] == ST_PASS) || (r_next.st[i] == ST_APPR);
      r_next.speed[i] = phase_speed(r_next.st[i], r_next.fast[i], dog_spd,
        fast_spd, cfg.app_feed); // [RULE10] [RULE11] [RULE13]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= r_next;
    end
  end

  assign axis_move = r.move;
  assign axis_dir_minus = r.dir_minus;
  assign axis_speed = r.speed;
  assign ref_point_reached_flag = r.reached;
  assign cfg.reached = r.reached;
  assign cfg.established = r.established;
  assign cfg.mode_active = mode_active;
  assign cfg.alm_mode = alm_mode;
  assign cfg.alm_dir = r.alm_dir;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_mode_alarm: assert property ((homing_mode_select && // [RULE3]
    |other_mode_select) |=> ##1 (op_alarm && op_alarm_code == ALM_MODE))
    else $error("mode conflict did not raise 0101");
  a_dir_alarm: assert property ((r.alm_dir && !alm_mode) |=> // [RULE14]
    (op_alarm && op_alarm_code == ALM_DIR))
    else $error("wrong direction did not raise 0003");
  a_one_pre_phase: assert property ($onehot0(pre_busy)) // [RULE8]
    else $error("two axes before approach at once");

  for (genvar i = 0; i < NUM_AXES; i++) begin : g_chk
    a_stop_at_ref: assert property ((r.st[i] == ST_APPR && // [RULE12]
      mode_active && at_ref_point[i]) |=> (r.st[i] == ST_DONE &&
      r.reached[i] && !r.move[i] && r.speed[i] == 16'h0000))
      else $error("axis did not stop at reference point");
    a_approach_holds: assert property ((r.st[i] == ST_APPR && // [RULE7]
      mode_active && !at_ref_point[i]) |=> (r.st[i] == ST_APPR && r.move[i]))
      else $error("approach abandoned early");
    a_final_dir: assert property ((r.st[i] != ST_APPR ##1 // [RULE9]
      r.st[i] == ST_APPR) |-> r.dir_minus[i] == $past(cfg.final_minus[i]))
      else $error("approach not in final direction");
    a_appr_speed: assert property ((r.st[i] == ST_APPR) |-> // [RULE11]
      r.speed[i] == $past(cfg.app_feed))
      else $error("approach speed wrong");
    a_dog_speed: assert property ((r.st[i] == ST_FEED && // [RULE10]
      !r.fast[i]) |-> r.speed[i] == ($past(rapid_traverse_select) ?
      $past(cfg.home_feed) : man_speed($past(manual_feedrate_code))))
      else $error("dog-type feed speed wrong");
    a_fast_speed: assert property ((r.st[i] == ST_FEED && // [RULE13]
      r.fast[i]) |-> r.speed[i] == ($past(rapid_traverse_select) ?
      $past(cfg.rapid_feed) : man_speed($past(manual_feedrate_code))))
      else $error("high-speed feed speed wrong");
    a_pattern_pick: assert property ( // [RULE4] [RULE5]
      (r.st[i] == ST_IDLE ##1 r.st[i] == ST_FEED) |-> r.fast[i] ==
      $past(cfg.hs_sel && (cfg.abs_est || r.established[i])))
      else $error("wrong homing pattern chosen");
    a_fast_toward: assert property ((r.st[i] == ST_IDLE ##1 // [RULE14]
      r.st[i] == ST_FEED && r.fast[i]) |->
      r.dir_minus[i] == $past(cfg.final_minus[i]))
      else $error("high-speed started away from point");
    a_reached_drop: assert property ((r.reached[i] && // [RULE15]
      (!at_ref_point[i] || !mode_active)) |=> !r.reached[i])
      else $error("reached flag did not drop");
    c_dog_same: cover property (r.st[i] == ST_FEED ##1 r.st[i] == ST_APPR
      ##[1:50] r.st[i] == ST_DONE);
    c_dog_pass: cover property (r.st[i] == ST_PASS ##1 r.st[i] == ST_APPR);
    c_fast_done: cover property (r.st[i] == ST_FEED && r.fast[i] ##1
      r.st[i] == ST_DONE);
  end

  c_parallel: cover property (r.st[0] == ST_APPR && r.st[1] == ST_FEED);
endmodule
`default_nettype wire

// >>> testbench/rprs_plc_model.sv
// rprs_plc_model: ladder-side model that drives mode and feed selects
// assumes the bench calls its tasks just after a rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module rprs_plc_model (
  output var logic homing_mode_select,
  output var logic [7:0] other_mode_select,
  output var rprs_pkg::rprs_axes_t feed_select_plus,
  output var rprs_pkg::rprs_axes_t feed_select_minus,
  output var logic rapid_traverse_select,
  output var logic [4:0] manual_feedrate_code
);
  import rprs_pkg::*;
  initial begin
    homing_mode_select = 1'b0;
    other_mode_select = 8'h00;
    feed_select_plus = 3'h0;
    feed_select_minus = 3'h0;
    rapid_traverse_select = 1'b0;
    manual_feedrate_code = 5'h00;
  end
  task automatic set_mode(input logic h, input logic [7:0] o);
    homing_mode_select <= h;
    other_mode_select <= o;
  endtask
  // one direction per axis: a ladder never asks for both at once
  task automatic feed(input rprs_axes_t p, input rprs_axes_t m);
    feed_select_plus <= p;
    feed_select_minus <= m & ~p;
  endtask
  task automatic set_speed(input logic rapid, input logic [4:0] c);
    rapid_traverse_select <= rapid;
    manual_feedrate_code <= c;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// tb: self-checking bench for the reference point return sequencer
// assumes rprs_top and the ladder model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rprs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  rprs_addr_t reg_addr = 8'h00;
  rprs_data_t reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic homing_mode_select;
  logic [7:0] other_mode_select;
  rprs_axes_t feed_select_plus;
  rprs_axes_t feed_select_minus;
  logic rapid_traverse_select;
  logic [4:0] manual_feedrate_code;
  rprs_axes_t near_dog = 3'h0;
  rprs_axes_t at_ref_point = 3'h0;
  rprs_axes_t axis_move;
  rprs_axes_t axis_dir_minus;
  rprs_axes_t ref_point_reached_flag;
  logic [47:0] axis_speed;
  logic op_alarm;
  logic [15:0] op_alarm_code;
  logic snap = 1'b0;
  logic rd_q = 1'b0;
  logic [63:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  rprs_speed_t man;
  rprs_speed_t app;
  logic [4:0] code;
  rprs_addr_t adr[6] = '{OFS_CTRL, OFS_HOME_FEED, OFS_APPR_FEED,
    OFS_RAPID_FEED, OFS_ALARM, 8'h18};
  logic [31:0] dflt[6] = '{32'h0, {16'h0, HOME_FEED_RST},
    {16'h0, APPR_FEED_RST}, {16'h0, RAPID_FEED_RST}, 32'h0, 32'h0};
  // direction only matters while the axis moves
  wire [63:0] obs = {6'h0, op_alarm, op_alarm_code, ref_point_reached_flag,
    axis_move,
    axis_dir_minus & axis_move, axis_speed[31:0]};

  always #12.5 ref_clk = ~ref_clk;

  rprs_plc_model u_plc (
    .homing_mode_select(homing_mode_select),
    .other_mode_select(other_mode_select),
    .feed_select_plus(feed_select_plus),
    .feed_select_minus(feed_select_minus),
    .rapid_traverse_select(rapid_traverse_select),
    .manual_feedrate_code(manual_feedrate_code)
  );

  rprs_top u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .homing_mode_select(homing_mode_select),
    .other_mode_select(other_mode_select),
    .feed_select_plus(feed_select_plus),
    .feed_select_minus(feed_select_minus),
    .rapid_traverse_select(rapid_traverse_select),
    .manual_feedrate_code(manual_feedrate_code),
    .near_dog(near_dog),
    .at_ref_point(at_ref_point),
    .axis_move(axis_move),
    .axis_dir_minus(axis_dir_minus),
    .axis_speed(axis_speed),
    .ref_point_reached_flag(ref_point_reached_flag),
    .op_alarm(op_alarm),
    .op_alarm_code(op_alarm_code)
  );

  task automatic compare(input logic [63:0] got);
    logic [63:0] e;
    checks_done++;
    e = (exp_q.size() == 0) ? 64'hx : exp_q.pop_front();
    if (got !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_q <= reg_rd;
    if (rd_q) compare({32'h0, reg_rdata});
    if (snap) compare(obs);
    // the third axis is never started, so its speed word must stay zero
    if (snap) begin
      checks_done++;
      if (axis_speed[47:32] !== 16'h0) begin
        num_errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
          axis_speed[47:32], 16'h0);
      end
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input rprs_addr_t a, input rprs_data_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    step(1);
    reg_wr <= 1'b0;
    step(1);
  endtask
  task automatic rd(input rprs_addr_t a, input logic [31:0] e);
    exp_q.push_back({32'h0, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    step(1);
    reg_rd <= 1'b0;
    step(1);
  endtask
  task automatic chk(input rprs_alm_t c, input rprs_axes_t r, input
    rprs_axes_t m, input rprs_axes_t d, input rprs_speed_t s1, input
    rprs_speed_t s0);
    exp_q.push_back({6'h0, c != ALM_NONE, c, r, m, d, s1, s0});
    snap <= 1'b1;
    step(1);
    snap <= 1'b0;
    step(1);
  endtask
  task automatic wait_alarm();
    for (int i = 0; i < 8 && op_alarm !== 1'b1; i++) step(1);
    if (op_alarm !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(36));
    step(4);
    rst <= 1'b0;
    step(1);
    for (int i = 0; i < 6; i++) rd(adr[i], dflt[i]);
    wr(OFS_STATUS, 32'hffff_ffff);
    rd(OFS_STATUS, 32'h0);
    app = 16'($urandom_range(1, 65535));
    code = 5'($urandom_range(1, 31));
    man = {11'h0, code} * MAN_STEP;
    wr(OFS_APPR_FEED, {16'h0, app});
    rd(OFS_APPR_FEED, {16'h0, app});
    u_plc.set_speed(1'b0, code);
    u_plc.set_mode(1'b1, 8'h00);
    step(3);
    rd(OFS_STATUS, 32'h40);
    // first return of each axis is dog-type, same direction as final
    u_plc.feed(3'h1, 3'h0);
    step(1);
    chk(ALM_NONE, 3'h0, 3'h1, 3'h0, 16'h0, man);
    u_plc.set_speed(1'b1, code);
    step(1);
    chk(ALM_NONE, 3'h0, 3'h1, 3'h0, 16'h0, HOME_FEED_RST);
    near_dog <= 3'h1;
    step(1);
    chk(ALM_NONE, 3'h0, 3'h1, 3'h0, 16'h0, app);
    u_plc.feed(3'h2, 3'h0);
    step(1);
    chk(ALM_NONE, 3'h0, 3'h3, 3'h0, HOME_FEED_RST, app);
    at_ref_point <= 3'h1;
    step(1);
    chk(ALM_NONE, 3'h1, 3'h2, 3'h0, HOME_FEED_RST, 16'h0);
    near_dog <= 3'h3;
    step(1);
    chk(ALM_NONE, 3'h1, 3'h2, 3'h0, app, 16'h0);
    at_ref_point <= 3'h3;
    step(1);
    chk(ALM_NONE, 3'h3, 3'h0, 3'h0, 16'h0, 16'h0);
    u_plc.feed(3'h0, 3'h0);
    at_ref_point <= 3'h2;
    step(1);
    chk(ALM_NONE, 3'h2, 3'h0, 3'h0, 16'h0, 16'h0);
    // axis 0 final entry minus, started plus: runs through the dog
    wr(OFS_CTRL, 32'h4);
    near_dog <= 3'h2;
    u_plc.feed(3'h1, 3'h0);
    step(1);
    chk(ALM_NONE, 3'h2, 3'h1, 3'h0, 16'h0, HOME_FEED_RST);
    near_dog <= 3'h3;
    step(1);
    chk(ALM_NONE, 3'h2, 3'h1, 3'h0, 16'h0, HOME_FEED_RST);
    near_dog <= 3'h2;
    step(1);
    chk(ALM_NONE, 3'h2, 3'h1, 3'h1, 16'h0, app);
    at_ref_point <= 3'h3;
    step(1);
    chk(ALM_NONE, 3'h3, 3'h0, 3'h0, 16'h0, 16'h0);
    // established axis with high-speed chosen
    u_plc.feed(3'h0, 3'h0);
    at_ref_point <= 3'h2;
    wr(OFS_CTRL, 32'h5);
    u_plc.feed(3'h0, 3'h1);
    step(1);
    chk(ALM_NONE, 3'h2, 3'h1, 3'h1, 16'h0, RAPID_FEED_RST);
    u_plc.set_speed(1'b0, code);
    step(1);
    chk(ALM_NONE, 3'h2, 3'h1, 3'h1, 16'h0, man);
    at_ref_point <= 3'h3;
    step(1);
    chk(ALM_NONE, 3'h3, 3'h0, 3'h0, 16'h0, 16'h0);
    u_plc.feed(3'h0, 3'h0);
    at_ref_point <= 3'h2;
    step(1);
    u_plc.feed(3'h1, 3'h0);
    wait_alarm();
    chk(ALM_DIR, 3'h2, 3'h0, 3'h0, 16'h0, 16'h0);
    u_plc.feed(3'h0, 3'h0);
    step(2);
    wr(OFS_ALARM, 32'h0);
    rd(OFS_ALARM, 32'h0);
    // homing selected together with another mode
    u_plc.set_mode(1'b1, 8'($urandom_range(1, 255)));
    wait_alarm();
    chk(ALM_MODE, 3'h0, 3'h0, 3'h0, 16'h0, 16'h0);
    rd(OFS_ALARM, {16'h0, ALM_MODE});
    // homing dropped while an axis moves
    u_plc.set_mode(1'b1, 8'h00);
    at_ref_point <= 3'h0;
    step(3);
    wr(OFS_ALARM, 32'h0);
    u_plc.feed(3'h0, 3'h1);
    step(2);
    u_plc.set_mode(1'b0, 8'h00);
    wait_alarm();
    chk(ALM_MODE, 3'h0, 3'h0, 3'h0, 16'h0, 16'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
